// ===== analog_scale_window_monitor.sv
// Analog window monitor and analog amplifier sharing one scaling path.
// Assumes sources arrive as flat vectors and a program-cycle strobe arrives
// from the controller sequencer; all inputs synchronous to clk.
`timescale 1ns/100ps
`include "analog_scale_map.svh"

module analog_scale_window_monitor
(
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst,
	// Program cycle strobe and power return pulse
	input  wire logic                       cycleStrobe,
	input  wire logic                       powerUp,
	// Analog sources, flat vectors of 16-bit values
	input  wire logic [8*16-1:0]            physicalAnalogInput,
	input  wire logic [64*16-1:0]           analogFlag,
	input  wire logic [32*16-1:0]           netAnalogInput,
	input  wire logic [8*16-1:0]            analogOutFeedback,
	input  wire logic [16*16-1:0]           netAnalogOutput,
	input  wire logic [256*16-1:0]          blockActualValue,
	// Monitor configuration
	input  wire analog_scale_pkg::srcSel_t  monSrcSel,
	input  wire analog_scale_pkg::srcIdx_t  monSrcIdx,
	input  wire analog_scale_pkg::blkNum_t  monSrcBlk,
	input  wire analog_scale_pkg::aval_t    monGain,
	input  wire analog_scale_pkg::aval_t    monOffset,
	input  wire logic                       upperMarginSrc,
	input  wire logic [15:0]                upperMargin,
	input  wire analog_scale_pkg::blkNum_t  upperMarginBlk,
	input  wire logic                       lowerMarginSrc,
	input  wire logic [15:0]                lowerMargin,
	input  wire analog_scale_pkg::blkNum_t  lowerMarginBlk,
	input  wire logic                       retentive,
	input  wire logic                       captureEnable,
	// Amplifier configuration
	input  wire analog_scale_pkg::srcSel_t  ampSrcSel,
	input  wire analog_scale_pkg::srcIdx_t  ampSrcIdx,
	input  wire analog_scale_pkg::blkNum_t  ampSrcBlk,
	input  wire analog_scale_pkg::aval_t    ampGain,
	input  wire analog_scale_pkg::aval_t    ampOffset,
	// Outputs
	output logic                            monitorOut,
	output analog_scale_pkg::aval_t         scaledAnalogOut,
	output analog_scale_pkg::aval_t         monitorLive,
	output analog_scale_pkg::aval_t         monitorRef,
	output logic                            cycleDone
);
	import analog_scale_pkg::*;

	state_t state_reg;  // Registered block state
	state_t state_next; // Next state

	// Every source class arrives as one flat vector of 16-bit words.
	// The helpers below cut a word out of such a vector by index.
	// All vectors are widened to the block table width first, so one
	// helper serves every class and the slice never runs off the end.
	// The cost is some wide zero padding, which synthesis trims away.

	// Pick one 16-bit value out of a flat vector
	function automatic aval_t pick(input logic [256*16-1:0] vec, input int unsigned idx);
		pick = aval_t'(vec[idx*16 +: 16]);
	endfunction : pick

	// Selector decode is shared by the monitor and the amplifier.
	// An index past the end of its class reads zero rather than wrapping,
	// so a mistyped index cannot silently alias another terminal.
	// Flags use all 64 codes of the index, so they need no range test.
	// Source selector over every analog class; out-of-range reads zero
	function automatic aval_t selectSource(input srcSel_t sel, input srcIdx_t idx, input blkNum_t blk);
		aval_t v;
		v = `RST_VAL;
		unique case (sel)
			`SRC_PHYS:   if (idx < 6'd8)  v = pick({{248*16{1'b0}}, physicalAnalogInput}, idx);
			`SRC_FLAG:   v = pick({{192*16{1'b0}}, analogFlag}, idx);
			`SRC_NETIN:  if (idx < 6'd32) v = pick({{224*16{1'b0}}, netAnalogInput}, idx);
			`SRC_AOUT:   if (idx < 6'd8)  v = pick({{248*16{1'b0}}, analogOutFeedback}, idx);
			`SRC_NETOUT: if (idx < 6'd16) v = pick({{240*16{1'b0}}, netAnalogOutput}, idx);
			`SRC_BLOCK:  v = pick(blockActualValue, blk);
			default:     v = `RST_VAL; // Unused selector codes
		endcase
		selectSource = v;
	endfunction : selectSource

	// Gain is held in hundredths, so the product is divided by one hundred.
	// Division truncates toward zero; rounding was traded for a plain divider.
	// Parameters beyond their legal span are clamped, not rejected,
	// so a bad setting still gives a bounded result.
	// The 32-bit product cannot overflow: 32767 times 1000 fits easily.
	// Shared scaling: value times gain (hundredths), plus offset, clamped
	function automatic aval_t scaleValue(input aval_t x, input aval_t gain, input aval_t offs);
		logic signed [31:0] g;
		logic signed [31:0] o;
		logic signed [31:0] r;
		g = 32'(gain);
		o = 32'(offs);
		if (g > 32'(`GAIN_MAX)) g = 32'(`GAIN_MAX);
		if (g < 32'(`GAIN_MIN)) g = 32'(`GAIN_MIN);
		if (o > 32'(`OFFSET_MAX)) o = 32'(`OFFSET_MAX);
		if (o < 32'(`OFFSET_MIN)) o = 32'(`OFFSET_MIN);
		r = (32'(x) * g) / `GAIN_SCALE + o;
		if (r > `AOUT_MAX) r = `AOUT_MAX;
		if (r < `AOUT_MIN) r = `AOUT_MIN;
		scaleValue = aval_t'(r[15:0]);
	endfunction : scaleValue

	// A margin may follow the live value of another block.
	// A negative block value would shrink the band inside out,
	// so it is read as zero; a large one is held to the margin limit.
	// Margin from parameter or another block, clamped to legal span
	function automatic logic [15:0] marginOf(input logic src, input logic [15:0] par, input blkNum_t blk);
		logic signed [15:0] b;
		logic [15:0]        m;
		b = pick(blockActualValue, blk);
		if (src == `MSRC_BLOCK)
			m = (b < 0) ? 16'h0000 : 16'(b);
		else
			m = par;
		marginOf = (m > `MARGIN_MAX) ? `MARGIN_MAX : m;
	endfunction : marginOf

	aval_t              monScaled; // Live scaled monitor input
	aval_t              ampScaled; // Live scaled amplifier input
	logic signed [17:0] bandHi;    // Reference plus upper margin
	logic signed [17:0] bandLo;    // Reference minus lower margin
	logic               outside;   // Live value outside band

	// The band is worked out two bits wider than a value, because the
	// reference plus a full margin can exceed the 16-bit signed span.
	// Both band edges count as inside, so equal values keep the output low.
	// Decimal places of either function never reach this logic
	// Scaling and band test; decimal places never enter here (display only)
	always_comb
	begin
		monScaled = scaleValue(selectSource(monSrcSel, monSrcIdx, monSrcBlk), monGain, monOffset);
		ampScaled = scaleValue(selectSource(ampSrcSel, ampSrcIdx, ampSrcBlk), ampGain, ampOffset);
		bandHi    = 18'(state_reg.refVal) + 18'($signed({2'b00, marginOf(upperMarginSrc, upperMargin, upperMarginBlk)}));
		bandLo    = 18'(state_reg.refVal) - 18'($signed({2'b00, marginOf(lowerMarginSrc, lowerMargin, lowerMarginBlk)}));
		outside   = (18'(monScaled) > bandHi) || (18'(monScaled) < bandLo);
	end

	// A non-retentive power return takes precedence over a strobe in the same cycle.
	// The enable edge is judged between strobes, not between clocks,
	// so an enable pulse shorter than a program cycle may go unseen.
	// A capture forces the output low, since live equals reference then.
	// Next-state logic, evaluated on the program-cycle strobe or a non-retentive power return
	always_comb
	begin
		state_next         = state_reg;
		state_next.cycDone = 1'b0;
		// Non-retentive state drops on power return
		if (powerUp && !retentive)
		begin
			state_next.enPrev     = 1'b0;
			state_next.refVal     = `RST_VAL;
			state_next.monitorOut = 1'b0;
		end
		else if (cycleStrobe)
		begin
			state_next.enPrev    = captureEnable;
			state_next.ampOut    = ampScaled;
			state_next.monLive   = monScaled;
			state_next.cycDone   = 1'b1;
			if (captureEnable && !state_reg.enPrev)
			begin
				// Fresh capture; band reference starts at the live value
				state_next.refVal     = monScaled;
				state_next.monitorOut = 1'b0;
			end
			else if (!captureEnable)
				state_next.monitorOut = 1'b0;
			else
				state_next.monitorOut = outside;
		end
	end

	// Hard reset always clears, retentive or not; only the power return
	// pulse respects the retention setting. Keep reset for true cold starts.
	// State register; retained state survives only if reset is not pulsed
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	// Every output is a plain copy of a state flip-flop, so downstream
	// blocks never see a combinational glitch from the scaling path.
	// Outputs straight from the state register
	assign monitorOut      = state_reg.monitorOut;
	assign scaledAnalogOut = state_reg.ampOut;
	assign monitorLive     = state_reg.monLive;
	assign monitorRef      = state_reg.refVal;
	assign cycleDone       = state_reg.cycDone;
endmodule : analog_scale_window_monitor

// ===== analog_scale_map.svh
// Constants for the analog scaling monitor and amplifier.
// Assumes integer internal analog values; gain is held in hundredths.
`ifndef ANALOG_SCALE_MAP_SVH
`define ANALOG_SCALE_MAP_SVH

// Gain limits in hundredths (-10.00 .. 10.00)
`define GAIN_MAX        16'sd1000
`define GAIN_MIN        (-16'sd1000)
`define GAIN_SCALE      32'sd100
// Offset limits
`define OFFSET_MAX      16'sd10000
`define OFFSET_MIN      (-16'sd10000)
// Margin upper limit
`define MARGIN_MAX      16'd20000
// Amplifier output limits
`define AOUT_MAX        32'sd32767
`define AOUT_MIN        (-32'sd32767)
// Physical input span, internal full scale
`define PHYS_FULL       16'sd1000
// Decimal places limit
`define DEC_MAX         2'd3
// Source selector codes
`define SRC_PHYS        3'h0
`define SRC_FLAG        3'h1
`define SRC_NETIN       3'h2
`define SRC_AOUT        3'h3
`define SRC_NETOUT      3'h4
`define SRC_BLOCK       3'h5
// Margin source codes
`define MSRC_PARAM      1'b0
`define MSRC_BLOCK      1'b1
// Reset values
`define RST_VAL         16'sh0000

`endif

// ===== analog_scale_pkg.sv
// Types shared by the analog scaling monitor.
// Assumes the constants header is included by the design file.
package analog_scale_pkg;
	typedef logic signed [15:0] aval_t;   // Internal analog value
	typedef logic [2:0]         srcSel_t; // Source class selector
	typedef logic [5:0]         srcIdx_t; // Index within class
	typedef logic [7:0]         blkNum_t; // Function block number

	// Registered state of the whole block
	typedef struct packed {
		logic  cycActive;   // Never set; holds its reset value of zero
		logic  enPrev;      // Capture enable of last cycle
		aval_t refVal;      // Captured scaled reference
		logic  monitorOut;  // Monitor output
		aval_t ampOut;      // Amplifier output
		aval_t monLive;     // Last live scaled value
		logic  cycDone;     // Cycle finished pulse
	} state_t;
endpackage : analog_scale_pkg

// ===== analog_scale_window_monitor_asserts.sv
// Checker for the monitor and amplifier outputs, bound to the block.
// Assumes it sees the block's ports only.
`timescale 1ns/100ps
module analog_scale_window_monitor_asserts
(
	// Watched ports
	input wire logic clk, rst, cycleStrobe, powerUp, retentive, captureEnable,
	input wire logic upperMarginSrc, lowerMarginSrc, monitorOut, cycleDone,
	input wire logic [15:0] upperMargin, lowerMargin,
	input wire analog_scale_pkg::aval_t monitorLive, monitorRef, scaledAnalogOut
);
	import analog_scale_pkg::*;
	wire take = cycleStrobe && !(powerUp && !retentive);	// Strobe not overridden
	logic enLast;	// Enable at the last taken strobe
	// Cleared with the state, so a capture may follow a power return
	always_ff @(posedge clk or posedge rst)
		if (rst) enLast <= 1'b0;
		else if (powerUp && !retentive) enLast <= 1'b0;
		else if (take) enLast <= captureEnable;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_cap; take && captureEnable && !enLast; endsequence
	sequence s_cmp; take && captureEnable && enLast && !upperMarginSrc && !lowerMarginSrc; endsequence
	property p_done; take |=> cycleDone; endproperty
	a_done: assert property (p_done) else $error("Missing cycle done");
	property p_idle; !cycleStrobe && !powerUp |=> !cycleDone && $stable(monitorOut) && $stable(scaledAnalogOut); endproperty
	a_idle: assert property (p_idle) else $error("Output moved between strobes");
	property p_cap; s_cap |=> monitorRef == monitorLive && !monitorOut; endproperty
	a_cap: assert property (p_cap) else $error("Reference not captured");
	property p_low; take && !captureEnable |=> !monitorOut; endproperty
	a_low: assert property (p_low) else $error("Output high with enable low");
	// Margins within range, so no clamp applies
	property p_band; s_cmp ##0 (upperMargin <= 16'h4E20 && lowerMargin <= 16'h4E20) |=> monitorOut ==
		(int'(monitorLive) > int'(monitorRef) + int'($past(upperMargin)) ||
		int'(monitorLive) < int'(monitorRef) - int'($past(lowerMargin))); endproperty
	a_band: assert property (p_band) else $error("Band decision wrong");
	property p_clip; scaledAnalogOut != 16'sh8000; endproperty
	a_clip: assert property (p_clip) else $error("Amplifier out of range");
	property p_clear; powerUp && !retentive |=> !monitorOut && monitorRef == 16'sh0000; endproperty
	a_clear: assert property (p_clear) else $error("State kept without retention");
	property p_keep; powerUp && retentive && !cycleStrobe |=> $stable(monitorRef) && $stable(monitorOut); endproperty
	a_keep: assert property (p_keep) else $error("Retained state lost");
endmodule : analog_scale_window_monitor_asserts
bind analog_scale_window_monitor analog_scale_window_monitor_asserts chk_u (.*);

// ===== analog_source_model.sv
// Model of the analog sources feeding the block.
// Assumes one test level; flags and network values come from testbench constants.
`timescale 1ns/100ps
module analog_source_model
(
	// Test level in, sources out
	input wire logic [15:0] level,
	output logic [127:0]    physicalAnalogInput,
	output logic [4095:0]   blockActualValue
);
	// Terminals span 0..1000 only; block values may run wider
	wire logic [15:0] phys = ($signed(level) < 0) ? 16'h0000 : ($signed(level) > 16'sh03E8) ? 16'h03E8 : level;
	// Terminal outputs likewise take only 0..1000; a normalizing stage would sit here
	assign physicalAnalogInput = {8{phys}};
	assign blockActualValue = {256{level}};
endmodule : analog_source_model

// ===== analog_scale_window_monitor_tb.sv
// Testbench for the monitor and amplifier, stepped from two tables.
// Assumes the source model fans one level out to terminals and blocks.
`timescale 1ns/100ps
module analog_scale_window_monitor_tb;
	import analog_scale_pkg::*;
	typedef struct packed {logic [15:0] lv; logic en, pu, ret; srcSel_t sel; logic out; aval_t rf, live, amp;} step_t;
	logic clk = 1'b0, rst = 1'b1, cycleStrobe = 1'b0, powerUp = 1'b0, retentive = 1'b0, captureEnable = 1'b0;
	logic upperMarginSrc = 1'b0, lowerMarginSrc = 1'b0, monitorOut, cycleDone;
	logic [15:0] upperMargin = 16'h0032, lowerMargin = 16'h001E, level = 16'h01F4;
	srcSel_t monSrcSel = 3'h0, ampSrcSel = 3'h5;
	srcIdx_t monSrcIdx = 6'h00, ampSrcIdx = 6'h00;
	blkNum_t monSrcBlk = 8'h00, ampSrcBlk = 8'h03, upperMarginBlk = 8'h00, lowerMarginBlk = 8'h00;
	// Monitor gain 2.00, offset -100; amplifier gain 20.00 must clamp to 10.00
	aval_t monGain = 16'h00C8, monOffset = 16'hFF9C, ampGain = 16'h07D0, ampOffset = 16'h2710;
	aval_t scaledAnalogOut, monitorLive, monitorRef; // Amplifier feeds analog sinks only
	// Other source classes carry distinct constants so a wrong selector shows
	logic [127:0] physicalAnalogInput, analogOutFeedback = {8{16'h012C}};
	logic [1023:0] analogFlag = {64{16'h0064}};
	logic [511:0] netAnalogInput = {32{16'h00C8}};
	logic [255:0] netAnalogOutput = {16{16'h0190}};
	logic [4095:0] blockActualValue;
	int mismatches = 0, n_compared = 0;
	// Capture, both band edges, block source with clamp, kept then cleared state
	step_t tab [8] = '{
		'{16'h01F4, 1'b1, 1'b0, 1'b0, 3'h0, 1'b0, 16'h0384, 16'h0384, 16'h3A98},
		'{16'h020E, 1'b1, 1'b0, 1'b0, 3'h0, 1'b1, 16'h0384, 16'h03B8, 16'h3B9C},
		'{16'h020D, 1'b1, 1'b0, 1'b0, 3'h0, 1'b0, 16'h0384, 16'h03B6, 16'h3B92},
		'{16'h01E5, 1'b1, 1'b0, 1'b0, 3'h0, 1'b0, 16'h0384, 16'h0366, 16'h3A02},
		'{16'h01E4, 1'b1, 1'b0, 1'b0, 3'h0, 1'b1, 16'h0384, 16'h0364, 16'h39F8},
		'{16'h1388, 1'b0, 1'b0, 1'b0, 3'h5, 1'b0, 16'h0384, 16'h26AC, 16'h7FFF},
		'{16'h012C, 1'b0, 1'b1, 1'b1, 3'h5, 1'b0, 16'h0384, 16'h0000, 16'h0000},
		'{16'h012C, 1'b0, 1'b1, 1'b0, 3'h5, 1'b0, 16'h0000, 16'h0000, 16'h0000}};
	// Remaining source classes, then both margins taken from block 0
	step_t tab2 [8] = '{
		'{16'h012C, 1'b0, 1'b0, 1'b0, 3'h1, 1'b0, 16'h0000, 16'h0064, 16'h32C8},
		'{16'h012C, 1'b0, 1'b0, 1'b0, 3'h2, 1'b0, 16'h0000, 16'h012C, 16'h32C8},
		'{16'h012C, 1'b0, 1'b0, 1'b0, 3'h3, 1'b0, 16'h0000, 16'h01F4, 16'h32C8},
		'{16'h012C, 1'b0, 1'b0, 1'b0, 3'h4, 1'b0, 16'h0000, 16'h02BC, 16'h32C8},
		'{16'h01F4, 1'b1, 1'b0, 1'b0, 3'h0, 1'b0, 16'h0384, 16'h0384, 16'h3A98},
		'{16'h03E9, 1'b1, 1'b0, 1'b0, 3'h0, 1'b0, 16'h0384, 16'h076C, 16'h4E2A},
		'{16'h014E, 1'b1, 1'b0, 1'b0, 3'h0, 1'b0, 16'h0384, 16'h0238, 16'h341C},
		'{16'h014D, 1'b1, 1'b0, 1'b0, 3'h0, 1'b1, 16'h0384, 16'h0236, 16'h3412}};
	analog_source_model src_u (.level(level), .physicalAnalogInput(physicalAnalogInput), .blockActualValue(blockActualValue));
	analog_scale_window_monitor dut_u (.*);
	initial forever #25 clk = ~clk;
	// Compare and count
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		mismatches += (seen !== exp);
		if (seen !== exp) $display("Error at %0t: seen %h expected %h", $time, seen, exp);
	endtask : check
	// Counts, verdict, end of run; a hang adds one mismatch
	task automatic summarize(input int hung);
		mismatches += hung;
		$display("Compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize
	// Hang guard, over eight times the expected run
	initial #20000 summarize(1);
	// One strobe or power return; margins from parameters or from block 0
	task automatic run_step(input step_t s, input logic ms);
		@(posedge clk);
		{level, captureEnable, powerUp, retentive, monSrcSel} <= {s.lv, s.en, s.pu, s.ret, s.sel};
		{upperMarginSrc, lowerMarginSrc} <= {2{ms}};
		cycleStrobe <= !s.pu;
		@(posedge clk);
		{cycleStrobe, powerUp} <= 2'h0;
		@(negedge clk);
		check(monitorOut, s.out);
		check(monitorRef, s.rf);
		if (!s.pu) check(cycleDone, 16'h0001);
		if (!s.pu) check(monitorLive, s.live);
		if (!s.pu) check(scaledAnalogOut, s.amp);
	endtask : run_step
	// Reset, then the two step tables
	initial
	begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		foreach (tab[i]) run_step(tab[i], 1'b0);
		foreach (tab2[i]) run_step(tab2[i], i >= 4);
		summarize(0);
	end
endmodule : analog_scale_window_monitor_tb
